// ### design/alu_flag_unit.sv
// ALU flag unit that computes zero, nibble carry and carry for one operation.
`timescale 1ns/1ps
module alu_flag_unit
   import core_sfr_pkg::*;
(
   input wire alu_op_t op,
   input wire logic [7:0] operand_a,
   input wire logic [7:0] operand_b,
   input wire logic [7:0] logic_result,
   input wire logic carry_in,
   output logic [7:0] result,
   output alu_flags_t flags,
   output logic affects_zero,
   output logic affects_arith
);
   logic [8:0] full_sum;
   logic [4:0] low_sum;
   logic [7:0] addend;

   // Subtraction adds the two's complement, so carry acts as not-borrow.
   always_comb
   begin
      addend = (op == alu_sub) ? 8'((~operand_b) + 8'h01) : operand_b;
      full_sum = {1'b0, operand_a} + {1'b0, addend};
      low_sum = {1'b0, operand_a[3:0]} + {1'b0, addend[3:0]};
      result = logic_result;
      flags = '0;
      affects_zero = 1'b0;
      affects_arith = 1'b0;
      case (op)
         alu_logic:
         begin
            affects_zero = 1'b1;
         end
         alu_add, alu_sub:
         begin
            result = full_sum[7:0];
            affects_zero = 1'b1;
            affects_arith = 1'b1;
            // Zero subtrahend is forced to carry 1; its 8-bit complement wraps to zero.
            flags.carry = full_sum[8] | ((op == alu_sub) && (operand_b == 8'h00));
            flags.nibble = low_sum[4] | ((op == alu_sub) && (operand_b[3:0] == 4'h0));
         end
         alu_rotate_right:
         begin
            result = {carry_in, operand_a[7:1]};
            flags.carry = operand_a[0];
         end
         alu_rotate_left:
         begin
            result = {operand_a[6:0], carry_in};
            flags.carry = operand_a[7];
         end
         default:
         begin
            result = logic_result;
         end
      endcase
      flags.zero = (result == 8'h00);
   end
endmodule

// ### design/core_sfr_pkg.sv
// Package with register offsets, field positions, reset values and carrier types.
package core_sfr_pkg;
   localparam logic [7:0] STATUS_OFFSET = 8'h03;
   localparam logic [7:0] IRQ_CONTROL_OFFSET = 8'h0B;
   localparam logic [7:0] OPTION_OFFSET = 8'h81;
   localparam logic [6:0] OFFSET_LOW_MASK = 7'h7F;
   localparam logic [7:0] STATUS_RESET = 8'h18;
   localparam logic [7:0] OPTION_RESET = 8'hFF;
   localparam logic [7:0] IRQ_CONTROL_RESET = 8'h00;
   localparam int BIT_CARRY = 0;
   localparam int BIT_NIBBLE = 1;
   localparam int BIT_ZERO = 2;
   localparam int BIT_SLEEP_N = 3;
   localparam int BIT_WDOG_N = 4;
   localparam int BIT_BANK = 5;
   localparam int BIT_PULLUP_OFF = 7;
   localparam int BIT_EXT_RISE = 6;
   localparam int BIT_CLK_SRC = 5;
   localparam int BIT_EXT_EDGE = 4;
   localparam int BIT_PSC_WDOG = 3;
   localparam int BIT_GLOBAL_EN = 7;
   localparam int BIT_PERIPH_EN = 6;
   localparam int BIT_TOV_EN = 5;
   localparam int BIT_EXT_EN = 4;
   localparam int BIT_PC_EN = 3;
   localparam int BIT_TOV_FLAG = 2;
   localparam int BIT_EXT_FLAG = 1;
   localparam int BIT_PC_FLAG = 0;
   localparam int PIN_COUNT = 6;

   typedef enum logic [2:0] {
      alu_none,
      alu_logic,
      alu_add,
      alu_sub,
      alu_rotate_right,
      alu_rotate_left
   } alu_op_t;

   // Result of the ALU flag stage handed to the register bank.
   typedef struct packed {
      logic zero;
      logic nibble;
      logic carry;
   } alu_flags_t;

   // Register access from the execution core.
   typedef struct packed {
      logic write;
      logic [7:0] addr;
      logic [7:0] data;
   } sfr_access_t;
endpackage

// ### design/core_status_option_irq_control.sv
// Status, timer option and interrupt control registers of the core.
`timescale 1ns/1ps
// How it works
// - Bank select bit chooses lower bank 00h-7Fh or upper bank 80h-FFh.
// - Watchdog expiry bit sets on power-up, clear or halt; clears on timeout.
// - Sleep bit sets on power-up or watchdog clear; clears on halt.
// - Zero flag follows whether an operation result is zero.
// - Nibble carry records carry from bit 3; borrow sense in subtraction.
// - Carry records carry from bit 7; borrow sense in subtraction.
// - Subtraction adds the two's complement of the second operand.
// - Rotates load carry with the bit shifted out.
// - Global pull-up off bit disables all pull-ups, else per-pin settings.
// - External interrupt edge follows the rising edge select bit.
// - Timer clocks from the external pin or the instruction cycle clock.
// - External timer edge is falling when edge select is one.
// - Shared prescaler goes to watchdog or timer by assignment bit.
// - Rate n divides timer by 2^(n+1) and watchdog by 2^n.
// - Timer runs undivided only when the prescaler goes to the watchdog.
// - Interrupt flags set regardless of enables.
// - Global enable passes unmasked interrupts; clear blocks all.
// - Peripheral enable gates all peripheral interrupts.
// - Timer rollover sets its flag; timer count is untouched by reset.
// - Any port pin change sets a held flag; mask bit also needed.
// - Flag-affecting writes to status leave flags; reset-cause bits read-only.
module core_status_option_irq_control
   import core_sfr_pkg::*;
#(
   parameter int PINS = PIN_COUNT
)
(
   input wire logic core_clk,
   input wire logic reset_n,
   input wire sfr_access_t access,
   output logic [7:0] read_data,
   input wire alu_op_t alu_op,
   input wire logic [7:0] operand_a,
   input wire logic [7:0] operand_b,
   input wire logic [7:0] logic_result,
   output logic [7:0] alu_result,
   input wire logic watchdog_clear_instr,
   input wire logic low_power_halt_instr,
   input wire logic watchdog_timeout,
   input wire logic instr_cycle_clock,
   input wire logic ext_irq_pin,
   input wire logic timer_ext_clock_pin,
   input wire logic [PINS-1:0] port_pins_5_to_0,
   input wire logic [PINS-1:0] pin_change_mask,
   input wire logic [PINS-1:0] pin_pullup_select,
   input wire logic basic_timer_rollover,
   input wire logic peripheral_irq_pending,
   output logic [PINS-1:0] pullup_enable,
   output logic bank_upper,
   output logic timer_tick,
   output logic watchdog_tick,
   output logic irq_request
);
   logic [7:0] status;
   logic [7:0] option;
   logic [7:0] irq_ctrl;
   logic [7:0] next_status;
   logic [7:0] next_option;
   logic [7:0] next_irq_ctrl;
   logic [7:0] prescaler;
   logic [7:0] next_prescaler;
   logic [2:0] ext_sync;
   logic [2:0] tclk_sync;
   logic [2:0] cyc_sync;
   logic [PINS-1:0] pin_meta;
   logic [PINS-1:0] pin_sync;
   logic [PINS-1:0] pin_last;
   logic [2:0] sync_live;
   alu_flags_t flags;
   logic affects_zero;
   logic affects_arith;
   logic wr_status;
   logic wr_option;
   logic wr_irq;
   logic ext_edge;
   logic tclk_edge;
   logic cyc_edge;
   logic source_tick;
   logic psc_out;
   logic [7:0] rate_mask;

   // Elaboration refuses pin counts that the mask and select ports cannot carry.
   if (PINS < 1 || PINS > 8)
   begin
      $error("PINS must lie between 1 and 8.");
   end

   alu_flag_unit alu_flag_unit_inst (
      .op(alu_op),
      .operand_a(operand_a),
      .operand_b(operand_b),
      .logic_result(logic_result),
      .carry_in(status[BIT_CARRY]),
      .result(alu_result),
      .flags(flags),
      .affects_zero(affects_zero),
      .affects_arith(affects_arith)
   );

   // Status and interrupt control decode only the low seven address bits and appear in both banks; option decodes all eight bits.
   always_comb
   begin
      wr_status = 1'b0;
      wr_option = 1'b0;
      wr_irq = 1'b0;
      read_data = 8'h00;
      if (access.addr[6:0] == (STATUS_OFFSET[6:0] & OFFSET_LOW_MASK))
      begin
         wr_status = access.write;
         read_data = status;
      end
      else if (access.addr[6:0] == IRQ_CONTROL_OFFSET[6:0])
      begin
         wr_irq = access.write;
         read_data = irq_ctrl;
      end
      else if (access.addr == OPTION_OFFSET)
      begin
         wr_option = access.write;
         read_data = option;
      end
   end

   // Pins come from outside the clock domain, so each passes two flops first.
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         ext_sync <= 3'h0;
         tclk_sync <= 3'h0;
         cyc_sync <= 3'h0;
         pin_meta <= '0;
         pin_sync <= '0;
         pin_last <= '0;
         sync_live <= 3'h0;
      end
      else
      begin
         ext_sync <= {ext_sync[1:0], ext_irq_pin};
         tclk_sync <= {tclk_sync[1:0], timer_ext_clock_pin};
         cyc_sync <= {cyc_sync[1:0], instr_cycle_clock};
         pin_meta <= port_pins_5_to_0;
         pin_sync <= pin_meta;
         pin_last <= pin_sync;
         sync_live <= {sync_live[1:0], 1'b1};
      end
   end

   // Edge detection reads only the second and third stages.
   always_comb
   begin
      if (option[BIT_EXT_RISE])
      begin
         ext_edge = ext_sync[1] & ~ext_sync[2];
      end
      else
      begin
         ext_edge = ~ext_sync[1] & ext_sync[2];
      end
      if (option[BIT_EXT_EDGE])
      begin
         tclk_edge = ~tclk_sync[1] & tclk_sync[2];
      end
      else
      begin
         tclk_edge = tclk_sync[1] & ~tclk_sync[2];
      end
      // Stages may differ until they fill after reset, so no edge counts before then.
      ext_edge = ext_edge & sync_live[2];
      tclk_edge = tclk_edge & sync_live[2];
      cyc_edge = cyc_sync[1] & ~cyc_sync[2] & sync_live[2];
      source_tick = option[BIT_CLK_SRC] ? tclk_edge : cyc_edge;
   end

   // One shared ripple prescaler; its input is the timer source or the cycle clock.
   always_comb
   begin
      rate_mask = 8'((9'h002 << option[2:0]) - 9'h001);
      next_prescaler = prescaler;
      psc_out = 1'b0;
      if (option[BIT_PSC_WDOG])
      begin
         // Watchdog divides by 2^n, so mask is one bit shorter.
         if (cyc_edge)
         begin
            next_prescaler = 8'(prescaler + 8'h01);
            psc_out = ((prescaler & (rate_mask >> 1)) == (rate_mask >> 1));
         end
         timer_tick = source_tick;
         watchdog_tick = psc_out;
      end
      else
      begin
         if (source_tick)
         begin
            next_prescaler = 8'(prescaler + 8'h01);
            psc_out = ((prescaler & rate_mask) == rate_mask);
         end
         timer_tick = psc_out;
         watchdog_tick = cyc_edge;
      end
      if (wr_option)
      begin
         // Reassigning the prescaler restarts its count to avoid a stray tick.
         next_prescaler = 8'h00;
      end
   end

   // Status, option and interrupt control next values.
   always_comb
   begin
      next_status = status;
      next_option = option;
      next_irq_ctrl = irq_ctrl;
      if (wr_status)
      begin
         next_status[7:5] = access.data[7:5];
         if (!affects_zero)
         begin
            next_status[BIT_ZERO] = access.data[BIT_ZERO];
         end
         if (!affects_arith && alu_op != alu_rotate_left && alu_op != alu_rotate_right)
         begin
            next_status[1:0] = access.data[1:0];
         end
      end
      if (affects_zero)
      begin
         next_status[BIT_ZERO] = flags.zero;
      end
      if (affects_arith)
      begin
         next_status[BIT_NIBBLE] = flags.nibble;
         next_status[BIT_CARRY] = flags.carry;
      end
      if (alu_op == alu_rotate_left || alu_op == alu_rotate_right)
      begin
         next_status[BIT_CARRY] = flags.carry;
      end
      if (watchdog_clear_instr)
      begin
         next_status[BIT_WDOG_N] = 1'b1;
         next_status[BIT_SLEEP_N] = 1'b1;
      end
      else if (low_power_halt_instr)
      begin
         next_status[BIT_WDOG_N] = 1'b1;
         next_status[BIT_SLEEP_N] = 1'b0;
      end
      if (watchdog_timeout)
      begin
         next_status[BIT_WDOG_N] = 1'b0;
      end
      if (wr_option)
      begin
         next_option = access.data;
      end
      if (wr_irq)
      begin
         next_irq_ctrl = access.data;
      end
      // Hardware sets win over a same-cycle software clear.
      if (basic_timer_rollover)
      begin
         next_irq_ctrl[BIT_TOV_FLAG] = 1'b1;
      end
      if (ext_edge)
      begin
         next_irq_ctrl[BIT_EXT_FLAG] = 1'b1;
      end
      if (sync_live[2] && ((pin_sync & pin_change_mask) != (pin_last & pin_change_mask)))
      begin
         next_irq_ctrl[BIT_PC_FLAG] = 1'b1;
      end
   end

   // Registers only; the timer count itself lives outside and keeps its value.
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         status <= STATUS_RESET;
         option <= OPTION_RESET;
         irq_ctrl <= IRQ_CONTROL_RESET;
         prescaler <= 8'h00;
      end
      else
      begin
         status <= next_status;
         option <= next_option;
         irq_ctrl <= next_irq_ctrl;
         prescaler <= next_prescaler;
      end
   end

   // Outward controls and the combined interrupt request.
   always_comb
   begin
      bank_upper = status[BIT_BANK];
      pullup_enable = option[BIT_PULLUP_OFF] ? '0 : pin_pullup_select;
      irq_request = irq_ctrl[BIT_GLOBAL_EN] & (
         (irq_ctrl[BIT_TOV_EN] & irq_ctrl[BIT_TOV_FLAG]) |
         (irq_ctrl[BIT_EXT_EN] & irq_ctrl[BIT_EXT_FLAG]) |
         (irq_ctrl[BIT_PC_EN] & irq_ctrl[BIT_PC_FLAG]) |
         (irq_ctrl[BIT_PERIPH_EN] & peripheral_irq_pending));
   end
endmodule

// ### verification/core_sfr_checker.sv
// Checker for the status, option and interrupt control register bank.
`timescale 1ns/1ps
module core_sfr_checker
   import core_sfr_pkg::*;
#(
   parameter int PINS = PIN_COUNT
)
(
   input wire logic core_clk,
   input wire logic reset_n,
   input wire sfr_access_t access,
   input wire logic [7:0] read_data,
   input wire alu_op_t alu_op,
   input wire logic [7:0] operand_a,
   input wire logic [7:0] operand_b,
   input wire logic [7:0] logic_result,
   input wire logic [7:0] alu_result,
   input wire logic watchdog_clear_instr,
   input wire logic low_power_halt_instr,
   input wire logic watchdog_timeout,
   input wire logic [PINS-1:0] pin_pullup_select,
   input wire logic [PINS-1:0] pullup_enable,
   input wire logic bank_upper,
   input wire logic timer_tick,
   input wire logic irq_request
);
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (!reset_n);
   logic stat_sel;
   logic irq_sel;
   logic add_c;
   logic res_nil;
   // Reference values from the operands; the status word only shows them one edge later.
   assign stat_sel = (access.addr[6:0] == 7'h03);
   assign irq_sel = (access.addr[6:0] == 7'h0B);
   assign add_c = (({1'b0, operand_a} + {1'b0, operand_b}) > 9'h0FF);
   assign res_nil = (logic_result == 8'h00);
   property p_bank; stat_sel |-> read_data[BIT_BANK] == bank_upper; endproperty
   a_bank: assert property (p_bank) else $error("bank output differs from status");
   property p_tout; watchdog_timeout ##1 stat_sel |-> !read_data[BIT_WDOG_N]; endproperty
   a_tout: assert property (p_tout) else $error("timeout left expiry bit set");
   property p_halt;
      low_power_halt_instr && !watchdog_clear_instr && !watchdog_timeout ##1 stat_sel
         |-> read_data[4:3] == 2'b10;
   endproperty
   a_halt: assert property (p_halt) else $error("halt gave wrong cause bits");
   property p_zero;
      alu_op == alu_logic ##1 stat_sel |-> read_data[2] == $past(res_nil);
   endproperty
   a_zero: assert property (p_zero) else $error("zero flag wrong after logic op");
   property p_carry; alu_op == alu_add ##1 stat_sel |-> read_data[0] == $past(add_c); endproperty
   a_carry: assert property (p_carry) else $error("carry wrong after add");
   property p_sub; alu_op == alu_sub |-> alu_result == operand_a - operand_b; endproperty
   a_sub: assert property (p_sub) else $error("difference wrong");
   property p_pull;
      access.addr == OPTION_OFFSET |-> pullup_enable == (read_data[7] ? '0 : pin_pullup_select);
   endproperty
   a_pull: assert property (p_pull) else $error("pull-up enables wrong");
   property p_glob_off; irq_sel && !read_data[BIT_GLOBAL_EN] |-> !irq_request; endproperty
   a_glob_off: assert property (p_glob_off) else $error("request while disabled");
   property p_req;
      irq_sel && read_data[BIT_GLOBAL_EN] && read_data[BIT_EXT_EN] && read_data[BIT_EXT_FLAG]
         |-> irq_request;
   endproperty
   a_req: assert property (p_req) else $error("enabled flag gave no request");
   c_req: cover property (irq_request);
   c_tick: cover property (timer_tick);
   c_tout: cover property (watchdog_timeout);
endmodule

bind core_status_option_irq_control core_sfr_checker #(.PINS(PINS)) core_sfr_checker_inst (
   .core_clk(core_clk), .reset_n(reset_n), .access(access), .read_data(read_data),
   .alu_op(alu_op), .operand_a(operand_a), .operand_b(operand_b),
   .logic_result(logic_result), .alu_result(alu_result),
   .watchdog_clear_instr(watchdog_clear_instr), .low_power_halt_instr(low_power_halt_instr),
   .watchdog_timeout(watchdog_timeout), .pin_pullup_select(pin_pullup_select),
   .pullup_enable(pullup_enable), .bank_upper(bank_upper), .timer_tick(timer_tick),
   .irq_request(irq_request));

// ### verification/exec_core_model.sv
// Stand-in for the execution core that issues one access and ALU step per call.
`timescale 1ns/1ps
module exec_core_model
   import core_sfr_pkg::*;
(
   input wire logic core_clk,
   output sfr_access_t access,
   output alu_op_t alu_op,
   output logic [7:0] operand_a,
   output logic [7:0] operand_b,
   output logic [7:0] logic_result,
   output logic [2:0] ctl
);
   // Quiet core at time zero.
   initial
   begin
      access = '0;
      alu_op = alu_none;
      operand_a = 8'h00;
      operand_b = 8'h00;
      logic_result = 8'h00;
      ctl = 3'h0;
   end
   // One cycle from a falling edge; the address stays so the read path stays valid after.
   task automatic step(input logic w, input logic [7:0] ad, d, input alu_op_t op,
      input logic [7:0] a, b, input logic [2:0] c);
      @(negedge core_clk);
      access = {w, ad, (ad[6:0] == 7'h03) ? (d & 8'h3F) : d};
      alu_op = op;
      operand_a = a;
      operand_b = b;
      logic_result = a;
      ctl = c;
      @(negedge core_clk);
      access.write = 1'b0;
      alu_op = alu_none;
      ctl = 3'h0;
   endtask
endmodule

// ### verification/tb_top.sv
// Self-checking bench for the status, option and interrupt control registers.
`timescale 1ns/1ps
module tb_top;
   import core_sfr_pkg::*;
   logic core_clk = 1'b0;
   logic reset_n = 1'b0;
   sfr_access_t access;
   alu_op_t alu_op;
   logic [7:0] opa, opb, lres, read_data, alu_result;
   logic [2:0] ctl;
   logic icc = 1'b0, ext_pin = 1'b0, tck = 1'b0, tov = 1'b0, per = 1'b0;
   logic [5:0] pins = 6'h00, pu_sel = 6'h2A, pu_en;
   logic bank_upper, timer_tick, wd_tick, irq_request;
   int fail_count = 0, cmp_count = 0, ticks = 0, wd_ticks = 0;
   // Free-running 100 MHz core clock.
   initial
      forever #5 core_clk = ~core_clk;
   exec_core_model exec_core_model_inst (.core_clk(core_clk), .access(access), .alu_op(alu_op),
      .operand_a(opa), .operand_b(opb), .logic_result(lres), .ctl(ctl));
   core_status_option_irq_control core_status_option_irq_control_inst (.core_clk(core_clk),
      .reset_n(reset_n), .access(access), .read_data(read_data), .alu_op(alu_op),
      .operand_a(opa), .operand_b(opb), .logic_result(lres), .alu_result(alu_result),
      .watchdog_clear_instr(ctl[0]), .low_power_halt_instr(ctl[1]),
      .watchdog_timeout(ctl[2]), .instr_cycle_clock(icc), .ext_irq_pin(ext_pin),
      .timer_ext_clock_pin(tck), .port_pins_5_to_0(pins), .pin_change_mask(6'h3F),
      .pin_pullup_select(pu_sel), .basic_timer_rollover(tov), .peripheral_irq_pending(per),
      .pullup_enable(pu_en), .bank_upper(bank_upper), .timer_tick(timer_tick),
      .watchdog_tick(wd_tick), .irq_request(irq_request));
   // Timer and watchdog pulses are counted here so scenarios only reset and read the counts.
   always @(posedge core_clk)
   begin
      if (timer_tick === 1'b1)
         ticks++;
      if (wd_tick === 1'b1)
         wd_ticks++;
   end
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      cmp_count++;
      if (g !== e)
      begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic op(input logic w, input logic [7:0] ad, d, input alu_op_t o = alu_none,
      input logic [7:0] a = 8'h00, b = 8'h00, input logic [2:0] c = 3'h0);
      exec_core_model_inst.step(w, ad, d, o, a, b, c);
   endtask
   task automatic rd(input string nm, input logic [7:0] ad, e);
      op(0, ad, 8'h00);
      chk(nm, e, read_data);
   endtask
   // Pins pass two sync flops and an edge detector, so six cycles is ample.
   task automatic settle();
      repeat (6) @(negedge core_clk);
   endtask
   task automatic t_regs();
      rd("status", 8'h03, STATUS_RESET);
      rd("option", OPTION_OFFSET, OPTION_RESET);
      rd("irq", 8'h8B, IRQ_CONTROL_RESET);
      rd("unmapped", 8'h05, 8'h00);
      op(1, 8'h83, 8'h27);
      rd("status wr", 8'h03, 8'h3F);
      chk("bank", 8'h01, {7'h0, bank_upper});
      op(1, 8'h03, 8'h00);
      chk("bank", 8'h00, {7'h0, bank_upper});
      op(1, OPTION_OFFSET, 8'h80);
      chk("pullups off", 8'h00, {2'b0, pu_en});
      op(1, OPTION_OFFSET, 8'h40);
      chk("pullups", {2'b0, pu_sel}, {2'b0, pu_en});
   endtask
   task automatic t_alu();
      alu_op_t o[8] = '{alu_add, alu_add, alu_sub, alu_sub, alu_logic, alu_rotate_right,
         alu_rotate_left, alu_rotate_left};
      logic [7:0] a[8] = '{8'h0F, 8'hFF, 8'h05, 8'h03, 8'h00, 8'h01, 8'h80, 8'h01};
      logic [7:0] b[8] = '{8'h01, 8'h01, 8'h05, 8'h05, 8'h00, 8'h00, 8'h00, 8'h00};
      logic [8:0] s;
      logic [4:0] n;
      logic [2:0] f;
      for (int i = 0; i < 8; i++)
      begin
         s = {1'b0, a[i]} + ((o[i] == alu_sub) ? {1'b0, ~b[i]} + 9'h001 : {1'b0, b[i]});
         n = {1'b0, a[i][3:0]}
            + ((o[i] == alu_sub) ? {1'b0, ~b[i][3:0]} + 5'h01 : {1'b0, b[i][3:0]});
         f = {s[7:0] == 8'h00, n[4], s[8]};
         if (o[i] == alu_logic)
            f = {a[i] == 8'h00, 2'b11};
         op(1, 8'h03, 8'h03, o[i], a[i], b[i]);
         if (i > 4)
            chk("rotate carry", {7'h0, (i == 5) ? a[i][0] : a[i][7]},
               {7'h0, read_data[0]});
         else
            chk("flags", {5'h0, f},
               {5'h0, read_data[2:0]});
      end
   endtask
   task automatic t_cause();
      logic [2:0] c[3] = '{3'b100, 3'b010, 3'b001};
      logic [1:0] e[3] = '{2'b01, 2'b10, 2'b11};
      for (int i = 0; i < 3; i++)
      begin
         op(0, 8'h03, 8'h00, alu_none, 8'h00, 8'h00, c[i]);
         chk("reset cause", {6'h0, e[i]}, {6'h0, read_data[4:3]});
      end
   endtask
   task automatic t_irq();
      op(1, 8'h0B, 8'h00);
      ext_pin = 1'b1;
      settle();
      rd("ext flag", 8'h0B, 8'h02);
      chk("no request", 8'h00, {7'h0, irq_request});
      op(1, 8'h0B, 8'h00);
      ext_pin = 1'b0;
      settle();
      rd("fall ignored", 8'h0B, 8'h00);
      op(1, 8'h0B, 8'h90);
      ext_pin = 1'b1;
      settle();
      rd("ext enabled", 8'h0B, 8'h92);
      chk("request", 8'h01, {7'h0, irq_request});
      op(1, 8'h0B, 8'h00);
      tov = 1'b1;
      @(negedge core_clk) tov = 1'b0;
      pins = 6'h01;
      settle();
      rd("tov and change", 8'h0B, 8'h05);
      op(1, 8'h0B, 8'hC0);
      per = 1'b1;
      @(negedge core_clk);
      chk("periph on", 8'h01, {7'h0, irq_request});
      op(1, 8'h0B, 8'h80);
      chk("periph off", 8'h00, {7'h0, irq_request});
      per = 1'b0;
   endtask
   task automatic t_timer();
      logic [7:0] opt[4] = '{8'h00, 8'h08, 8'h07, 8'h0A};
      int cyc[4] = '{8, 8, 512, 8};
      int ex[4] = '{4, 8, 2, 8};
      int wex[4] = '{8, 8, 512, 2};
      for (int i = 0; i < 4; i++)
      begin
         op(1, OPTION_OFFSET, opt[i]);
         ticks = 0;
         wd_ticks = 0;
         repeat (2 * cyc[i])
         begin
            repeat (2) @(negedge core_clk);
            icc = ~icc;
         end
         settle();
         chk("ticks", ex[i][7:0], ticks[7:0]);
         chk("wdog ticks", wex[i][7:0], wd_ticks[7:0]);
      end
      op(1, OPTION_OFFSET, 8'h38);
      ticks = 0;
      tck = 1'b1;
      settle();
      chk("ext rise", 8'h00, ticks[7:0]);
      tck = 1'b0;
      settle();
      chk("ext fall", 8'h01, ticks[7:0]);
   endtask
   task automatic close_out();
      $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // Main sequence after a 12-cycle reset.
   initial
   begin
      repeat (12) @(negedge core_clk);
      reset_n = 1'b1;
      t_regs();
      t_alu();
      t_cause();
      t_irq();
      t_timer();
      close_out();
   end
   // The run needs about 2300 cycles; 20000 means a hang.
   initial
   begin
      #200000;
      fail_count++;
      close_out();
   end
endmodule
